// ==== src/swc_pkg.sv ====
// Constants, carrier structs and state types of the switch control register.
// Assumes a single 25 MHz reference clock domain.
package swc_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [6:0] SW_CTRL_ADDR = 7'h20;
   localparam logic [7:0] SW_CTRL_RESET = 8'h00;
   localparam int FAULT_MSB = 7;
   localparam int FAULT_LSB = 6;
   localparam int RSV_MSB = 5;
   localparam int RSV_LSB = 4;
   localparam int FOURTH_BIT = 3;
   localparam int THIRD_BIT = 2;
   localparam int SECOND_BIT = 1;
   localparam int FIRST_BIT = 0;
   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] RSV_VALUE = 2'h0;

   // ----------------------------------------
   // Serial frame
   // ----------------------------------------
   localparam int READ_FLAG_BIT = 7;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam int SYNC_STAGES = 2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic sclk;
      logic csN;
      logic sdi;
   } swc_spi_in_type;

   localparam swc_spi_in_type SPI_IDLE = 3'h2;

   typedef struct packed {
      logic fourth;
      logic third;
      logic second;
      logic first;
   } swc_close_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CMD,
      ST_DATA,
      ST_DONE
   } swc_state_type;

   typedef struct packed {
      swc_state_type st;
      logic sclkPrev;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic isRead;
      logic hit;
      logic [7:0] rdShift;
      logic sdo;
      swc_close_type closeEn;
   } swc_regs_type;

endpackage : swc_pkg

// ==== src/swc_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to ref_clk; output is safe for logic.
`timescale 1ns/10ps
`default_nettype none
module swc_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ----------------------------------------
   // Stages
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= RST;
         sync_q <= RST;
      end else if (clkEn) begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule : swc_sync
`default_nettype wire

// ==== src/swc_switch_control.sv ====
// Switch control register behind a serial peripheral port.
// Assumes serial pins are asynchronous and much slower than ref_clk.
// How it works
// - Register lives at address 0x20; reset clears it, all switches open.
// - Bits 7:6 read the fault code; 00 means no fault found.
// - Bit 3 closes the fourth switch when one, opens it when zero.
// - Bit 2 closes the third switch when one, opens it when zero.
// - Bit 1 closes the second switch when one, opens it when zero.
// - Bit 0 closes the first switch when one, opens it when zero.
`timescale 1ns/10ps
`default_nettype none
module swc_switch_control (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdi,
   output logic sdo,
   output logic sdoOeN,
   input wire logic [1:0] faultCode,
   output logic firstSwitchClose,
   output logic secondSwitchClose,
   output logic thirdSwitchClose,
   output logic fourthSwitchClose
);

   // ----------------------------------------
   // Pin synchronisation
   // ----------------------------------------
   swc_pkg::swc_spi_in_type pinRaw;
   swc_pkg::swc_spi_in_type spi;

   assign pinRaw = '{sclk: sclk, csN: csN, sdi: sdi};

   // Pins pass two flops before any logic reads them
   swc_sync #(
      .W(3),
      .RST(swc_pkg::SPI_IDLE)
   ) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clkEn(clkEn),
      .din(pinRaw),
      .dout(spi)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   swc_pkg::swc_regs_type q;
   swc_pkg::swc_regs_type d;

   logic rise;
   logic fall;
   logic [7:0] newByte;
   logic byteEnd;
   logic wrDone;
   logic rdStart;
   logic [7:0] readValue;

   assign rise = clkEn && !spi.csN && spi.sclk && !q.sclkPrev;
   assign fall = clkEn && !spi.csN && !spi.sclk && q.sclkPrev;
   assign newByte = {q.shift[6:0], spi.sdi};
   assign byteEnd = rise && (q.bitCnt == swc_pkg::BYTE_LAST);
   assign wrDone = byteEnd && (q.st == swc_pkg::ST_DATA) && !q.isRead && q.hit;
   assign rdStart = byteEnd && (q.st == swc_pkg::ST_CMD) && newByte[swc_pkg::READ_FLAG_BIT];

   // Read image: reserved bits forced to zero, fault code taken live
   always_comb begin
      readValue = '0;
      readValue[swc_pkg::FAULT_MSB:swc_pkg::FAULT_LSB] = faultCode;
      readValue[swc_pkg::RSV_MSB:swc_pkg::RSV_LSB] = swc_pkg::RSV_VALUE;
      readValue[swc_pkg::FOURTH_BIT] = q.closeEn.fourth;
      readValue[swc_pkg::THIRD_BIT] = q.closeEn.third;
      readValue[swc_pkg::SECOND_BIT] = q.closeEn.second;
      readValue[swc_pkg::FIRST_BIT] = q.closeEn.first;
   end

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   always_comb begin
      d = q;
      if (clkEn) begin
         d.sclkPrev = spi.sclk;
         if (spi.csN) begin
            d.st = swc_pkg::ST_IDLE;
            d.bitCnt = '0;
            d.isRead = 1'b0;
            d.hit = 1'b0;
         end else begin
            case (q.st)
               swc_pkg::ST_IDLE: begin
                  d.st = swc_pkg::ST_CMD;
                  d.bitCnt = '0;
               end
               swc_pkg::ST_CMD: begin
                  if (rise) begin
                     d.shift = newByte;
                     d.bitCnt = q.bitCnt + 4'h1;
                  end
                  if (byteEnd) begin
                     d.st = swc_pkg::ST_DATA;
                     d.bitCnt = '0;
                     d.isRead = newByte[swc_pkg::READ_FLAG_BIT];
                     d.hit = (newByte[6:0] == swc_pkg::SW_CTRL_ADDR);
                     // Unmapped reads shift out zeros
                     d.rdShift = d.hit ? readValue : '0;
                  end
               end
               swc_pkg::ST_DATA: begin
                  if (rise) begin
                     d.shift = newByte;
                     d.bitCnt = q.bitCnt + 4'h1;
                  end
                  if (fall && q.isRead) begin
                     d.sdo = q.rdShift[7];
                     d.rdShift = {q.rdShift[6:0], 1'b0};
                  end
                  if (byteEnd) begin
                     d.st = swc_pkg::ST_DONE;
                  end
                  // Reserved and fault bits of the written byte are dropped
                  if (wrDone) begin
                     d.closeEn.fourth = newByte[swc_pkg::FOURTH_BIT];
                     d.closeEn.third = newByte[swc_pkg::THIRD_BIT];
                     d.closeEn.second = newByte[swc_pkg::SECOND_BIT];
                     d.closeEn.first = newByte[swc_pkg::FIRST_BIT];
                  end
               end
               swc_pkg::ST_DONE: begin
                  d.st = swc_pkg::ST_DONE;
               end
               default: begin
                  d.st = swc_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{st: swc_pkg::ST_IDLE, sclkPrev: 1'b0, shift: '0, bitCnt: '0, isRead: 1'b0, hit: 1'b0,
                rdShift: '0, sdo: 1'b0, closeEn: swc_pkg::SW_CTRL_RESET[3:0]};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign sdo = q.sdo;
   // Active low; the line is driven only in the data byte of a read
   assign sdoOeN = !(q.isRead && (q.st == swc_pkg::ST_DATA) && !spi.csN);
   assign firstSwitchClose = q.closeEn.first;
   assign secondSwitchClose = q.closeEn.second;
   assign thirdSwitchClose = q.closeEn.third;
   assign fourthSwitchClose = q.closeEn.fourth;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_reset_open:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      $rose(arst_n) |-> (q.closeEn == swc_pkg::SW_CTRL_RESET[3:0]) && sdoOeN && (q.st == swc_pkg::ST_IDLE))
      else $error("Switch enables not cleared after reset");

   a_write_fourth:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      wrDone |=> (q.closeEn.fourth == $past(newByte[3])) && (fourthSwitchClose == q.closeEn.fourth))
      else $error("Fourth switch enable not taken from write");

   a_write_low_three:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      wrDone |=> ({thirdSwitchClose, secondSwitchClose, firstSwitchClose} == $past(newByte[2:0])))
      else $error("Low switch enables not taken from write");

   a_enables_hold:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      !wrDone |=> $stable(q.closeEn))
      else $error("Switch enables changed without a register write");

   a_read_image:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rdStart && (newByte[6:0] == swc_pkg::SW_CTRL_ADDR)) |=>
         (q.rdShift == {$past(faultCode), 2'h0, $past(q.closeEn)}))
      else $error("Read image does not match fault code and enables");

   a_unmapped_zero:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      (rdStart && (newByte[6:0] != swc_pkg::SW_CTRL_ADDR)) |=> (q.rdShift == 8'h00) && !q.hit)
      else $error("Unmapped read does not return zero");

   a_sdo_shift:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      (fall && q.isRead && (q.st == swc_pkg::ST_DATA)) |=> (sdo == $past(q.rdShift[7])) && !sdoOeN)
      else $error("Serial output bit not driven from read image");

   a_sdo_release:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clkEn && spi.csN) |-> sdoOeN ##1 (q.st == swc_pkg::ST_IDLE))
      else $error("Serial output driven or frame kept outside chip select");

   a_unmapped_write:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      (byteEnd && (q.st == swc_pkg::ST_DATA) && !q.isRead && !q.hit) |=> $stable(q.closeEn))
      else $error("Write to another address changed the switch enables");

   a_read_no_write:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      (byteEnd && (q.st == swc_pkg::ST_DATA) && q.isRead) |=> $stable(q.closeEn))
      else $error("Read frame changed the switch enables");

   a_frame_abort:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      (clkEn && spi.csN && (q.st == swc_pkg::ST_DATA)) |=> $stable(q.closeEn))
      else $error("Cut frame changed the switch enables");

   a_freeze_state:
   assert property (@(posedge ref_clk) disable iff (!arst_n)
      !clkEn |=> $stable(q))
      else $error("State moved while the clock enable was low");

endmodule : swc_switch_control
`default_nettype wire

// ==== verif/swc_spi_host.sv ====
// SPI host model: mode 0, MSB first, 16-bit frames to the switch control register.
// Assumes ref_clk is the bench clock; each serial level lasts six clock periods.
`timescale 1ns/10ps
`default_nettype none
module swc_spi_host (
   input wire logic ref_clk,
   input wire logic sdo,
   output logic sclk,
   output logic csN,
   output logic sdi,
   output logic done,
   output logic [7:0] rxByte
);
   localparam int HALF = 6;
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      sdi = 1'b0;
      done = 1'b0;
      rxByte = 8'h00;
   end
   task automatic waitClk(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : waitClk
   // Fewer than 16 bits aborts the frame
   task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] data, input int nBits);
      logic [15:0] tx;
      tx = {rd, addr, data[7:6], 2'h0, data[3:0]};
      csN = 1'b0;
      waitClk(HALF);
      for (int i = 15; i >= 16 - nBits; i--) begin
         sdi = tx[i];
         waitClk(HALF);
         sclk = 1'b1;
         if (i < 8) begin
            rxByte = {rxByte[6:0], sdo};
         end
         waitClk(HALF);
         sclk = 1'b0;
      end
      waitClk(HALF);
      csN = 1'b1;
      sdi = ~sdi;
      waitClk(HALF);
      done = 1'b1;
      waitClk(1);
      done = 1'b0;
   endtask : frame
endmodule : swc_spi_host
`default_nettype wire

// ==== verif/swc_switch_control_bench.sv ====
// Self-checking bench for the switch control register.
// Assumes the host model frames every transfer; expectations are queued.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module swc_switch_control_bench;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic clkEn = 1'b1;
   logic [1:0] faultCode = 2'h0;
   logic sclk, csN, sdi, sdo, sdoOeN, done, sdoWire;
   logic sdoHeld = 1'b0;
   logic firstSwitchClose, secondSwitchClose, thirdSwitchClose, fourthSwitchClose;
   logic [3:0] swNow;
   logic [3:0] enMdl = 4'h0;
   logic [7:0] rxByte, data;
   logic [8:0] notes[$];
   logic [8:0] note;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 27;
   always #20 ref_clk = ~ref_clk;
   // Released line shows the inverse of its last driven level
   always @(posedge ref_clk) begin
      if (sdoOeN === 1'b0) begin
         sdoHeld <= sdo;
      end
   end
   assign sdoWire = (sdoOeN === 1'b0) ? sdo : ~sdoHeld;
   assign swNow = {fourthSwitchClose, thirdSwitchClose, secondSwitchClose, firstSwitchClose};
   swc_switch_control dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn), .sclk(sclk), .csN(csN),
      .sdi(sdi), .sdo(sdo), .sdoOeN(sdoOeN), .faultCode(faultCode), .firstSwitchClose(firstSwitchClose),
      .secondSwitchClose(secondSwitchClose), .thirdSwitchClose(thirdSwitchClose),
      .fourthSwitchClose(fourthSwitchClose));
   swc_spi_host host_u (.ref_clk(ref_clk), .sdo(sdoWire), .sclk(sclk), .csN(csN), .sdi(sdi), .done(done),
      .rxByte(rxByte));
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [6:0] addr, input logic [7:0] d, input int nBits);
      if (addr == swc_pkg::SW_CTRL_ADDR && nBits == 16) begin
         enMdl = d[3:0];
      end
      notes.push_back({5'h00, enMdl});
      host_u.frame(1'b0, addr, d, nBits);
   endtask : wr
   task automatic rdChk(input logic [6:0] addr);
      notes.push_back({1'b1, (addr == swc_pkg::SW_CTRL_ADDR) ? {faultCode, swc_pkg::RSV_VALUE, enMdl} : 8'h00});
      host_u.frame(1'b1, addr, 8'h00, 16);
   endtask : rdChk
   // -----------------------------
   // Result watcher
   // -----------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         wrap_up();
      end else if (done) begin
         note = notes.pop_front();
         if (note[8]) `CHK(rxByte, note[7:0])
         else `CHK({4'h0, swNow}, note[7:0])
      end
   end
   // -----------------------------
   // Stimulus
   // -----------------------------
   initial begin
      repeat (5) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK({4'h0, swNow}, swc_pkg::SW_CTRL_RESET)
      rdChk(swc_pkg::SW_CTRL_ADDR);
      for (int i = 0; i < 16; i++) begin
         data = 8'($random(seed));
         faultCode = i[1:0];
         wr(swc_pkg::SW_CTRL_ADDR, {data[7:4], i[3:0]}, 16);
         rdChk(swc_pkg::SW_CTRL_ADDR);
      end
      // Clock enable low: a whole write frame must leave the register alone
      clkEn = 1'b0;
      notes.push_back({5'h00, enMdl});
      host_u.frame(1'b0, swc_pkg::SW_CTRL_ADDR, {4'h0, ~enMdl}, 16);
      clkEn = 1'b1;
      rdChk(swc_pkg::SW_CTRL_ADDR);
      wr(7'h21, 8'h0a, 16);
      rdChk(7'h21);
      wr(swc_pkg::SW_CTRL_ADDR, 8'h05, 12);
      rdChk(swc_pkg::SW_CTRL_ADDR);
      @(posedge ref_clk);
      #1 arst_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK({4'h0, swNow}, swc_pkg::SW_CTRL_RESET)
      arst_n = 1'b1;
      enMdl = 4'h0;
      repeat (4) @(posedge ref_clk);
      #1;
      rdChk(swc_pkg::SW_CTRL_ADDR);
      wrap_up();
   end
endmodule : swc_switch_control_bench
`default_nettype wire
